// ==== sensor_exc_consts.svh ====
`ifndef SENSOR_EXC_CONSTS_SVH
`define SENSOR_EXC_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
// bus switch opening time, ns (longest time, rounds down)
`define SWITCH_OPEN_TIME_NS 2000
`define SWITCH_OPEN_CYC ((`SWITCH_OPEN_TIME_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
    (`SWITCH_OPEN_TIME_NS / `CLK_PERIOD_NS))
// reserve reset timeout, us
`define RESERVE_RESET_TIMEOUT_US 1000
`define RESERVE_RESET_CYC (`RESERVE_RESET_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)
// capacitor test reset period, us
`define CAPTEST_RESET_PERIOD_US 1000
`define CAPTEST_RESET_CYC (`CAPTEST_RESET_PERIOD_US * 1000 / `CLK_PERIOD_NS)
// frame timeout, us
`define FRAME_TIMEOUT_TIME_US 1000
`define FRAME_TIMEOUT_CYC (`FRAME_TIMEOUT_TIME_US * 1000 / `CLK_PERIOD_NS)
// length of one internal reset pulse, cycles
`define RESET_PULSE_CYC 16

// ----------------------------------------------------------------
// wishbone register map (byte addresses)
// ----------------------------------------------------------------
`define REG_STATUS 8'h00
`define REG_IRQ_STATUS 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_CONTROL 8'h0C

// irq status bit positions
`define IRQ_REG_UV 0
`define IRQ_RESERVE_UV 1
`define IRQ_RESERVE_RST 2
`define IRQ_CAPTEST 3
`define IRQ_FRAME_TO 4
`define IRQ_CRC 5
`define IRQ_WIDTH 6

// reset values
`define IRQ_MASK_RST 6'h00

`endif

// ==== sensor_exc_pkg.sv ====
`default_nettype none
package sensor_exc_pkg;

    // acceleration read answer source
    typedef enum logic [1:0] {
        ACC_NORMAL = 2'h0,
        ACC_ZERO = 2'h1,
        ACC_SELFTEST = 2'h2
    } acc_src_t;

    // device-level exception state
    typedef enum logic [3:0] {
        EXC_RUN = 4'h1,
        EXC_HOLD = 4'h2,
        EXC_PULSE = 4'h4,
        EXC_WAIT = 4'h8
    } exc_state_t;

endpackage
`default_nettype wire

// ==== sensor_exc_handler.sv ====
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_exc_consts.svh"

module sensor_exc_handler
    import sensor_exc_pkg::*;
#(
    parameter int RESERVE_CYC = `RESERVE_RESET_CYC,
    parameter int CAPTEST_CYC = `CAPTEST_RESET_CYC,
    parameter int FRAME_CYC = `FRAME_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // analog comparator levels, asynchronous
    input wire logic digital_regulator_out_low_i,
    input wire logic analog_regulator_out_low_i,
    input wire logic reserve_cap_node_low_i,
    input wire logic bus_input_line_low_i,
    input wire logic captest_fail_i,
    // factory memory check and self-test request, same clock
    input wire logic factory_crc_fail_i,
    input wire logic factory_lock_i,
    input wire logic selftest_request_i,
    // to the device core
    output logic core_reset_o,
    output logic bus_silent_o,
    output logic bus_switch_open_o,
    output logic error_flag_o,
    output logic selftest_active_flag_o,
    output logic low_reserve_flag_o,
    output logic [1:0] short_read_src_o,
    output logic [1:0] long_read_src_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt
    output logic irq_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // all state of the handler in one word
    typedef struct packed {
        // fault level synchronisers
        logic [4:0] s1;
        logic [4:0] s2;
        // reset sequencer and its timers
        exc_state_t st;
        logic [31:0] period_cnt;
        logic [31:0] reserve_cnt;
        logic [31:0] frame_cnt;
        logic [7:0] pulse_cnt;
        logic [1:0] cause;
        // switch, flags and read sources carried in responses
        logic sw_open;
        logic err;
        logic stf;
        logic lowres;
        logic [1:0] srd;
        logic [1:0] lrd;
        // interrupt and control registers
        logic [`IRQ_WIDTH-1:0] irq_st;
        logic [`IRQ_WIDTH-1:0] irq_mask;
        logic force_st_off;
        // bus answer
        logic ack;
        logic [31:0] rdat;
    } state_t;

    // registered copy and its next value
    state_t ff, nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // cause codes for the periodic reset
    localparam logic [1:0] CAUSE_RES = 2'h0;
    localparam logic [1:0] CAUSE_CAP = 2'h1;
    localparam logic [1:0] CAUSE_FRM = 2'h2;

    // period length for the active repeating cause
    function automatic logic [31:0] period_of(input logic [1:0] c);
        case (c)
            CAUSE_CAP: period_of = 32'(CAPTEST_CYC);
            CAUSE_FRM: period_of = 32'(FRAME_CYC);
            default: period_of = 32'(RESERVE_CYC);
        endcase
    endfunction

    // saturating increment of a timeout counter
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
    endfunction

    // true on the edge that starts a reset pulse for the given cause
    function automatic logic pulse_start(
        input exc_state_t cur,
        input exc_state_t nx,
        input logic [1:0] c,
        input logic [1:0] want
    );
        pulse_start = (nx == EXC_PULSE) && (cur != EXC_PULSE) && (c == want);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic reg_uv; // either regulator low
    logic res_low;
    logic frame_low;
    logic cap_fail;
    logic res_long;
    logic frame_long;
    logic repeat_req; // any cause that asks for a reset pulse
    logic [1:0] want_cause;
    logic wb_req;
    logic wb_wr;

    // synchronised fault levels
    assign reg_uv = ff.s2[0] | ff.s2[1];
    assign res_low = ff.s2[2];
    assign frame_low = ff.s2[3];
    assign cap_fail = ff.s2[4];
    // timed faults and the cause that wins
    assign res_long = res_low && (ff.reserve_cnt >= 32'(RESERVE_CYC));
    assign frame_long = frame_low && (ff.frame_cnt >= 32'(FRAME_CYC));
    assign repeat_req = res_long | cap_fail | frame_long;
    assign want_cause = cap_fail ? CAUSE_CAP : (res_long ? CAUSE_RES : CAUSE_FRM);
    // a request is taken only while no answer is out
    assign wb_req = wb_cyc_i & wb_stb_i & ~ff.ack;
    // writes land on the ack edge, so a master that quits early changes nothing
    assign wb_wr = ff.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // whole next state in one pass
    always_comb begin
        logic st_on;
        logic [`IRQ_WIDTH-1:0] ev;
        st_on = 1'b0;
        ev = '0;
        nxt = ff;
        // two-stage sync; first stage read only by the second
        nxt.s1 = {captest_fail_i, bus_input_line_low_i, reserve_cap_node_low_i,
            analog_regulator_out_low_i, digital_regulator_out_low_i};
        nxt.s2 = ff.s1;
        // dwell counters; reset only by the line recovering
        nxt.reserve_cnt = res_low ? sat_inc(ff.reserve_cnt) : 32'h0;
        nxt.frame_cnt = frame_low ? sat_inc(ff.frame_cnt) : 32'h0;
        // reset-type sequencer; supply loss overrides repeating resets
        case (ff.st)
            EXC_RUN: begin
                // regulator loss beats every repeating cause
                if (reg_uv) begin
                    nxt.st = EXC_HOLD;
                end else if (repeat_req) begin
                    nxt.st = EXC_PULSE;
                    nxt.cause = want_cause;
                    nxt.pulse_cnt = 8'h0;
                end
            end
            EXC_HOLD: begin
                // configuration is gone here; the master re-initialises
                if (!reg_uv) begin
                    nxt.st = EXC_RUN;
                end
            end
            EXC_PULSE: begin
                nxt.pulse_cnt = ff.pulse_cnt + 8'h1;
                // a pulse is cut short if a regulator drops
                if (reg_uv) begin
                    nxt.st = EXC_HOLD;
                end else if (ff.pulse_cnt >= 8'(`RESET_PULSE_CYC - 1)) begin
                    nxt.st = EXC_WAIT;
                    nxt.period_cnt = 32'h0;
                end
            end
            EXC_WAIT: begin
                nxt.period_cnt = ff.period_cnt + 32'h1;
                if (reg_uv) begin
                    nxt.st = EXC_HOLD;
                end else if (!repeat_req && !(res_low || frame_low)) begin
                    nxt.st = EXC_RUN; // configuration lost, master re-inits
                end else if (ff.period_cnt >= period_of(ff.cause) - 32'h1) begin
                    nxt.st = repeat_req ? EXC_PULSE : EXC_WAIT;
                    nxt.cause = repeat_req ? want_cause : ff.cause;
                    nxt.pulse_cnt = 8'h0;
                    nxt.period_cnt = 32'h0;
                end
            end
            default: nxt.st = EXC_HOLD;
        endcase
        // switch opens the cycle after detection, well inside the limit
        nxt.sw_open = (nxt.st != EXC_RUN);
        // flag-only exceptions; brief reserve dip keeps configuration
        st_on = selftest_request_i & ~ff.force_st_off;
        nxt.err = factory_crc_fail_i & factory_lock_i;
        nxt.stf = st_on;
        nxt.lowres = res_low;
        // a factory fault zeroes short reads even under self-test
        if (nxt.err) begin
            nxt.srd = ACC_ZERO;
            nxt.lrd = st_on ? ACC_SELFTEST : ACC_NORMAL;
        end else if (res_low) begin
            nxt.srd = st_on ? ACC_SELFTEST : ACC_ZERO;
            nxt.lrd = st_on ? ACC_SELFTEST : ACC_NORMAL;
        end else begin
            nxt.srd = st_on ? ACC_SELFTEST : ACC_NORMAL;
            nxt.lrd = st_on ? ACC_SELFTEST : ACC_NORMAL;
        end
        // interrupt events on rising conditions
        ev[`IRQ_REG_UV] = (nxt.st == EXC_HOLD) && (ff.st != EXC_HOLD);
        ev[`IRQ_RESERVE_UV] = res_low && (ff.reserve_cnt == 32'h0);
        ev[`IRQ_RESERVE_RST] = pulse_start(ff.st, nxt.st, nxt.cause, CAUSE_RES);
        ev[`IRQ_CAPTEST] = pulse_start(ff.st, nxt.st, nxt.cause, CAUSE_CAP);
        ev[`IRQ_FRAME_TO] = pulse_start(ff.st, nxt.st, nxt.cause, CAUSE_FRM);
        ev[`IRQ_CRC] = nxt.err && !ff.err;
        // wishbone single-cycle answer, set beats write-one-clear
        nxt.ack = wb_req;
        nxt.rdat = 32'h0;
        if (wb_wr) begin
            case (wb_adr_i)
                `REG_IRQ_STATUS: nxt.irq_st = ff.irq_st & ~wb_dat_i[`IRQ_WIDTH-1:0];
                `REG_IRQ_MASK: nxt.irq_mask = wb_dat_i[`IRQ_WIDTH-1:0];
                `REG_CONTROL: nxt.force_st_off = wb_dat_i[0];
                default: ;
            endcase
        end
        // set after clear so a new event is never lost
        nxt.irq_st = nxt.irq_st | ev;
        // reads sample the registers on the taking edge
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `REG_STATUS: nxt.rdat = {20'h0, ff.lrd, ff.srd, ff.st, ff.sw_open,
                    ff.lowres, ff.stf, ff.err};
                `REG_IRQ_STATUS: nxt.rdat = {26'h0, ff.irq_st};
                `REG_IRQ_MASK: nxt.rdat = {26'h0, ff.irq_mask};
                `REG_CONTROL: nxt.rdat = {31'h0, ff.force_st_off};
                default: nxt.rdat = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // one register bank; reset leaves the device held and silent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ff <= '0;
            ff.st <= EXC_HOLD;
            ff.sw_open <= 1'b1;
            ff.irq_mask <= `IRQ_MASK_RST;
        end else begin
            ff <= nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // core held during hold and pulse; silent through the whole wait too
    assign core_reset_o = (ff.st == EXC_HOLD) || (ff.st == EXC_PULSE);
    assign bus_silent_o = (ff.st != EXC_RUN);
    // switch, flags and read sources straight from flops
    assign bus_switch_open_o = ff.sw_open;
    assign error_flag_o = ff.err;
    assign selftest_active_flag_o = ff.stf;
    assign low_reserve_flag_o = ff.lowres;
    assign short_read_src_o = ff.srd;
    assign long_read_src_o = ff.lrd;
    // bus answer
    assign wb_dat_o = ff.rdat;
    assign wb_ack_o = ff.ack;
    // level interrupt
    assign irq_o = |(ff.irq_st & ff.irq_mask);

endmodule

`default_nettype wire

// ==== bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side bus master: frames and re-init
// ----------------------------------------
module bus_master_model #(
    parameter int GAP = 16
) (
    // clock, stall command from the bench and device silence
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic dev_silent_i,
    // line level and re-init state
    output logic line_low_o,
    output logic reinit_done_o
);
    int cnt = 0;
    // short signalling dips; a stall parks the line low past the frame timeout
    always @(posedge clk_i) begin
        cnt <= (cnt + 1) % GAP;
        line_low_o <= stall_i || (cnt < 3);
    end
    // configuration is lost while silent, so re-init once the device answers again
    always @(posedge clk_i) begin
        reinit_done_o <= !dev_silent_i;
    end
endmodule
`default_nettype wire

// ==== sensor_exc_handler_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sensor_exc_monitor
    import sensor_exc_pkg::*;
#(
    parameter int RESERVE_CYC = 50,
    parameter int CAPTEST_CYC = 50,
    parameter int FRAME_CYC = 50
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fault levels
    input wire logic digital_regulator_out_low_i,
    input wire logic analog_regulator_out_low_i,
    input wire logic reserve_cap_node_low_i,
    input wire logic bus_input_line_low_i,
    input wire logic captest_fail_i,
    input wire logic factory_crc_fail_i,
    input wire logic factory_lock_i,
    // outputs watched
    input wire logic core_reset_o,
    input wire logic bus_silent_o,
    input wire logic bus_switch_open_o,
    input wire logic error_flag_o,
    input wire logic selftest_active_flag_o,
    input wire logic low_reserve_flag_o,
    input wire logic [1:0] short_read_src_o,
    input wire logic [1:0] long_read_src_o
);
    int rcnt;
    int fcnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // run lengths of the two timed lows; margin covers the two-stage sync
    always_ff @(posedge clk_i) begin
        rcnt <= (rst_i || !reserve_cap_node_low_i) ? 0 : rcnt + 1;
        fcnt <= (rst_i || !bus_input_line_low_i) ? 0 : fcnt + 1;
    end
    sequence flags_held;
        ($stable(error_flag_o) && $stable(selftest_active_flag_o)
            && $stable(low_reserve_flag_o))[*3];
    endsequence
    a_reg_uv_hold: assert property (
        (digital_regulator_out_low_i || analog_regulator_out_low_i)[*5]
        |-> core_reset_o && bus_silent_o) else $error("regulator low without reset");
    a_switch_opens: assert property ($rose(bus_silent_o) |=> bus_switch_open_o)
        else $error("switch not opened");
    a_err_flag: assert property (!$past(rst_i) |-> error_flag_o == $past(factory_crc_fail_i
        && factory_lock_i)) else $error("error flag wrong");
    a_lowres_flag: assert property (reserve_cap_node_low_i[*5] |-> low_reserve_flag_o)
        else $error("low reserve flag missing");
    a_short_src: assert property (flags_held |-> short_read_src_o == (
        error_flag_o ? ACC_ZERO : selftest_active_flag_o ? ACC_SELFTEST :
        low_reserve_flag_o ? ACC_ZERO : ACC_NORMAL)) else $error("short source wrong");
    a_long_src: assert property (flags_held |-> long_read_src_o ==
        (selftest_active_flag_o ? ACC_SELFTEST : ACC_NORMAL)) else $error("long source wrong");
    a_captest_silent: assert property (captest_fail_i[*5] |-> bus_silent_o)
        else $error("captest not silent");
    a_frame_silent: assert property (fcnt > FRAME_CYC + 6 |-> bus_silent_o)
        else $error("frame timeout not silent");
    a_reserve_silent: assert property (rcnt > RESERVE_CYC + 6 |-> bus_silent_o)
        else $error("reserve timeout not silent");
endmodule
bind sensor_exc_handler sensor_exc_monitor #(.RESERVE_CYC(RESERVE_CYC),
    .CAPTEST_CYC(CAPTEST_CYC), .FRAME_CYC(FRAME_CYC)) u_sensor_exc_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .digital_regulator_out_low_i(digital_regulator_out_low_i),
    .analog_regulator_out_low_i(analog_regulator_out_low_i), .captest_fail_i(captest_fail_i),
    .reserve_cap_node_low_i(reserve_cap_node_low_i), .bus_input_line_low_i(bus_input_line_low_i),
    .factory_crc_fail_i(factory_crc_fail_i), .factory_lock_i(factory_lock_i),
    .core_reset_o(core_reset_o), .bus_silent_o(bus_silent_o), .error_flag_o(error_flag_o),
    .bus_switch_open_o(bus_switch_open_o), .selftest_active_flag_o(selftest_active_flag_o),
    .low_reserve_flag_o(low_reserve_flag_o), .short_read_src_o(short_read_src_o),
    .long_read_src_o(long_read_src_o));
`default_nettype wire

// ==== tb_sensor_exc_handler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_exc_handler;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic dig_low = 1'b0, ana_low = 1'b0, res_low = 1'b0, cap_fail = 1'b0, stall = 1'b0;
    logic crc = 1'b0, lock = 1'b1, st_req = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, dat_o, rdat;
    logic line_low, core_rst, silent, sw_open, err, stf, lowres, ack, irq, reinit;
    logic [1:0] srd, lrd;
    logic [2:0] cin [5] = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h2};
    logic [6:0] cexp [5] = '{7'h14, 7'h3A, 7'h44, 7'h66, 7'h2A};
    int err_count = 0, comparisons = 0;
    always #5 clk_i = ~clk_i;
    sensor_exc_handler #(.RESERVE_CYC(50), .CAPTEST_CYC(50), .FRAME_CYC(50)) u_sensor_exc_handler (
        .clk_i(clk_i), .rst_i(rst_i), .digital_regulator_out_low_i(dig_low),
        .analog_regulator_out_low_i(ana_low), .reserve_cap_node_low_i(res_low),
        .bus_input_line_low_i(line_low), .captest_fail_i(cap_fail), .factory_crc_fail_i(crc),
        .factory_lock_i(lock), .selftest_request_i(st_req), .core_reset_o(core_rst),
        .bus_silent_o(silent), .bus_switch_open_o(sw_open), .error_flag_o(err),
        .selftest_active_flag_o(stf), .low_reserve_flag_o(lowres), .short_read_src_o(srd),
        .long_read_src_o(lrd), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
    bus_master_model u_bus_master_model (.clk_i(clk_i), .stall_i(stall), .dev_silent_i(silent),
        .line_low_o(line_low), .reinit_done_o(reinit));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task wrap_up();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            wrap_up();
        end
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task wait_run();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (silent !== 1'b0 && n < 400);
        if (n >= 400) begin
            err_count++;
            wrap_up();
        end
        @(posedge clk_i);
    endtask
    // holds one reset-type cause long enough for two reset pulses
    task fault(input int k);
        int rises;
        logic prev;
        rises = 0;
        prev = 1'b0;
        @(posedge clk_i);
        {cap_fail, res_low, stall} <= {k == 0, k == 1, k == 2};
        repeat (220) begin
            @(posedge clk_i);
            rises += int'(core_rst && !prev);
            prev = core_rst;
        end
        chk(silent, 1);
        chk(rises >= 2, 1);
        {cap_fail, res_low, stall} <= 3'h0;
        wait_run();
        chk(reinit, 1);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run();
        wb(1'b0, 8'h10, 32'h0, rdat);
        chk(rdat, 32'h0);
        wb(1'b1, 8'h08, 32'h3F, rdat);
        // brief flag-only exceptions, well under the timeouts
        for (int i = 0; i < 5; i++) begin
            {crc, st_req, res_low} <= cin[i];
            repeat (10) @(posedge clk_i);
            chk({err, stf, lowres, srd, lrd}, cexp[i]);
            chk(core_rst | silent, 0);
            {crc, st_req, res_low} <= 3'h0;
            repeat (10) @(posedge clk_i);
        end
        chk(irq, 1);
        wb(1'b0, 8'h04, 32'h0, rdat);
        chk(rdat, 32'h22);
        wb(1'b1, 8'h04, 32'h22, rdat);
        wb(1'b1, 8'h08, 32'h0, rdat);
        crc <= 1'b1;
        wb(1'b1, 8'h0C, 32'h1, rdat);
        st_req <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({irq, stf, err}, 3'h1);
        {crc, st_req} <= 2'b00;
        wb(1'b1, 8'h0C, 32'h0, rdat);
        wb(1'b1, 8'h04, 32'h20, rdat);
        // regulator dips, digital then analog
        for (int j = 0; j < 2; j++) begin
            {ana_low, dig_low} <= (j == 0) ? 2'b01 : 2'b10;
            repeat (8) @(posedge clk_i);
            chk({core_rst, silent, sw_open}, 3'h7);
            {ana_low, dig_low} <= 2'b00;
            wait_run();
        end
        for (int k = 0; k < 3; k++) fault(k);
        wb(1'b0, 8'h04, 32'h0, rdat);
        chk(rdat, 32'h1F);
        chk(irq, 1'b0);
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
